// ### logic/dcr_top.sv
// Clock source, reset and operating mode configuration with an AXI4-Lite register slave
//
// Overview of operation
// - Reference code 01 makes the PLL run from the frame clock.
// - Internal bit clock gen plus slave role makes the device create bit clock.
// - Frame-clock PLL mode needs no other external clock.
// - Rate field: 00 is 48k range, 01 is 96k, 10/11 is 192k.
// - Ratio codes give 256/384/512/768, halved at 96k, quartered at 192k.
// - Reset pin low disables everything and holds minimal power.
// - After reset pin rises, 300 ms must pass before normal operation.
// - Global power-up cleared gives idle state, registers kept.
// - Sensor, PLL and regulator power-downs each affect only their section.
// - Soft reset restores register defaults, clocks default, analog stays powered.
// - Standalone strap high: no control port, defaults except strap options. The code still answers register reads and only ignores writes.
// - Standalone role strap: 0 master, 1 slave.
// - Standalone ratio strap: 0 gives 256, 1 gives 384, PLL on.
// - Standalone format strap: 0 I2S, 1 TDM chosen by two straps.
// - TDM straps: 00 four, 01 eight, 10 sixteen slots; 11 eight at 50%.
// - Standalone: master clock out buffers master clock in after reset.
// - Direct clock mode: PLL down, direct select set, 512 ratio.
// - PLL stays off after reset until global power-up is written, except in standalone.
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dcr_top #(
  parameter int unsigned STAB_CYCLES = dcr_pkg::STAB_CYCLES
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             powerup_reset_n,
  input  wire logic             standalone_strap,
  input  wire logic             role_strap,
  input  wire logic             ratio_strap,
  input  wire logic             format_strap,
  input  wire logic             tdm_variant_strap_a,
  input  wire logic             tdm_variant_strap_b,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_awaddr,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  output logic [1:0]            s_axi_bresp,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  input  wire logic [31:0]      s_axi_araddr,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output dcr_pkg::dcr_cfg_t     cfg
);

  dcr_pkg::dcr_state_t s;
  dcr_pkg::dcr_state_t next_s;

  localparam dcr_pkg::dcr_regs_t REGS_DEFAULT = '{
    clk0: dcr_pkg::CLK0_RST,
    clk1: dcr_pkg::CLK1_RST,
    dac0: dcr_pkg::DAC0_RST,
    dac1: dcr_pkg::DAC1_RST,
    pdn:  dcr_pkg::PDN_RST
  };

  // Ratio code to base multiple of the sample rate in the lowest range
  function automatic logic [9:0] base_ratio(input logic [1:0] code);
    logic [9:0] r;
    case (code)
      2'h0:    r = dcr_pkg::RATIO_256;
      2'h1:    r = dcr_pkg::RATIO_384;
      2'h2:    r = dcr_pkg::RATIO_512;
      default: r = dcr_pkg::RATIO_768;
    endcase
    return r;
  endfunction

  // Master clock stays fixed in Hz, so the multiple shrinks as the rate rises
  function automatic logic [9:0] scale_ratio(input logic [9:0] r, input logic [1:0] range);
    logic [9:0] o;
    case (range)
      dcr_pkg::RATE_48: o = r;
      dcr_pkg::RATE_96: o = r >> 1;
      default:          o = r >> 2;
    endcase
    return o;
  endfunction

  // Register read mux
  function automatic logic [31:0] read_reg(input dcr_pkg::dcr_state_t st, input logic [31:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      dcr_pkg::ADDR_CLK0: d[7:0] = st.regs.clk0;
      dcr_pkg::ADDR_CLK1: d[7:0] = st.regs.clk1;
      dcr_pkg::ADDR_DAC0: d[7:0] = st.regs.dac0;
      dcr_pkg::ADDR_DAC1: d[7:0] = st.regs.dac1;
      dcr_pkg::ADDR_PDN:  d[7:0] = st.regs.pdn;
      dcr_pkg::ADDR_STAT: d[7:0] = {2'h0, st.cfg.channels_unmuted, st.cfg.pll_enable,
                                    st.cfg.core_enable, st.straps.standalone, st.mute_toggled, st.stable};
      default:            d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  function automatic logic mapped(input logic [31:0] a);
    return a == dcr_pkg::ADDR_CLK0 || a == dcr_pkg::ADDR_CLK1 || a == dcr_pkg::ADDR_DAC0 ||
           a == dcr_pkg::ADDR_DAC1 || a == dcr_pkg::ADDR_PDN  || a == dcr_pkg::ADDR_STAT;
  endfunction

  // Next-state logic for bus slave, registers, wait counter and derived mode
  always_comb
  begin
    logic       sa;
    logic       active;
    logic       pll_powerdown;
    logic       wr_now;
    logic [7:0] wv;
    logic [1:0] ratio_code;
    logic [1:0] range;
    next_s = s;
    sa = 1'b0;
    active = 1'b0;
    pll_powerdown = 1'b0;
    wr_now = 1'b0;
    wv = 8'h00;
    ratio_code = 2'h0;
    range = 2'h0;

    next_s.pin_q = powerup_reset_n;

    // Capture straps on the rising reset pin; later strap changes are ignored
    if (powerup_reset_n && !s.pin_q)
    begin
      next_s.straps = '{standalone: standalone_strap, role: role_strap, ratio: ratio_strap,
                        fmt: format_strap, tdm_a: tdm_variant_strap_a, tdm_b: tdm_variant_strap_b};
    end

    // Write address and data are taken independently, in either order
    if (s_axi_awvalid && s.awready)
    begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready)
    begin
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata[7:0];
      next_s.wlane = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready)
      next_s.bvalid = 1'b0;

    if (s.aw_got && s.w_got && !s.bvalid)
    begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = mapped(s.awaddr) ? dcr_pkg::RESP_OKAY : dcr_pkg::RESP_SLVERR;
      // Standalone and held reset both leave the register file untouched
      wr_now = s.wlane && s.pin_q && !s.straps.standalone;
    end

    wv = s.wdata;
    if (wr_now)
    begin
      case (s.awaddr)
        dcr_pkg::ADDR_CLK0:
        begin
          if (wv[dcr_pkg::CLK0_SRST])
            next_s.regs = REGS_DEFAULT;
          else
            next_s.regs.clk0 = wv & ~(8'h01 << dcr_pkg::CLK0_SRST);
        end
        dcr_pkg::ADDR_CLK1: next_s.regs.clk1 = wv;
        dcr_pkg::ADDR_DAC0:
        begin
          next_s.regs.dac0 = wv;
          // Any change of the mute bit counts as the required toggle
          if (wv[dcr_pkg::DAC0_MUTE] != s.regs.dac0[dcr_pkg::DAC0_MUTE])
            next_s.mute_toggled = 1'b1;
        end
        dcr_pkg::ADDR_DAC1: next_s.regs.dac1 = wv;
        dcr_pkg::ADDR_PDN:  next_s.regs.pdn = wv;
        default:            next_s.regs = s.regs;
      endcase
    end

    // Read channel: one read at a time, answered the cycle after the address
    if (s.rvalid && s_axi_rready)
      next_s.rvalid = 1'b0;
    if (s_axi_arvalid && s.arready)
    begin
      next_s.rvalid = 1'b1;
      next_s.rdata = read_reg(s, s_axi_araddr);
      next_s.rresp = mapped(s_axi_araddr) ? dcr_pkg::RESP_OKAY : dcr_pkg::RESP_SLVERR;
    end

    // Stabilisation wait runs only while the pin is high
    if (s.pin_q && !s.stable)
    begin
      next_s.stab_cnt = s.stab_cnt + 27'h1;
      if (s.stab_cnt == 27'(STAB_CYCLES - 1))
        next_s.stable = 1'b1;
    end

    // Pin low wipes the register file and the wait; straps keep last capture
    if (!powerup_reset_n)
    begin
      next_s.regs = REGS_DEFAULT;
      next_s.stab_cnt = 27'h0;
      next_s.stable = 1'b0;
      next_s.mute_toggled = 1'b0;
    end

    // Derived operating mode, from the next state so outputs track in one cycle
    sa = next_s.straps.standalone;
    pll_powerdown = next_s.regs.pdn[dcr_pkg::PDN_PLL];
    active = next_s.pin_q && next_s.stable && (sa || next_s.regs.clk0[dcr_pkg::CLK0_PUP]);
    ratio_code = sa ? {1'b0, next_s.straps.ratio} : next_s.regs.clk0[dcr_pkg::CLK0_RATIO +: 2];
    range = sa ? dcr_pkg::RATE_48 : next_s.regs.dac0[dcr_pkg::DAC0_RATE +: 2];

    next_s.cfg.ready = next_s.stable;
    next_s.cfg.core_enable = active;
    // PLL is off after reset because its power-up bit defaults to zero; standalone forces it on
    next_s.cfg.pll_enable = next_s.pin_q && (sa || (next_s.regs.clk0[dcr_pkg::CLK0_PUP] && !pll_powerdown));
    next_s.cfg.pll_ref_frame = next_s.cfg.pll_enable && !sa &&
                               next_s.regs.clk0[dcr_pkg::CLK0_REF +: 2] == dcr_pkg::REF_FRAME;
    next_s.cfg.direct_clock = active && !sa && pll_powerdown && next_s.regs.clk1[dcr_pkg::CLK1_DIRECT];
    next_s.cfg.rate_range = range;
    next_s.cfg.mclk_ratio = next_s.pin_q ? scale_ratio(next_s.cfg.direct_clock ? dcr_pkg::RATIO_512
                                                       : base_ratio(ratio_code), range) : 10'h000;
    next_s.cfg.port_master = next_s.pin_q && (sa ? !next_s.straps.role
                                              : next_s.regs.dac1[dcr_pkg::DAC1_ROLE]);
    // Own bit clock only while slave; the PLL reference does not matter
    next_s.cfg.bitclk_gen = active && !sa && next_s.regs.dac1[dcr_pkg::DAC1_BCLK] &&
                            !next_s.regs.dac1[dcr_pkg::DAC1_ROLE];
    next_s.cfg.tdm_format = next_s.pin_q && sa && next_s.straps.fmt;
    next_s.cfg.tdm_slots = 5'h00;
    next_s.cfg.frame_50pct = 1'b0;
    if (next_s.cfg.tdm_format)
    begin
      case ({next_s.straps.tdm_a, next_s.straps.tdm_b})
        2'h0:    next_s.cfg.tdm_slots = dcr_pkg::SLOTS_4;
        2'h1:    next_s.cfg.tdm_slots = dcr_pkg::SLOTS_8;
        2'h2:    next_s.cfg.tdm_slots = dcr_pkg::SLOTS_16;
        default:
        begin
          next_s.cfg.tdm_slots = dcr_pkg::SLOTS_8;
          next_s.cfg.frame_50pct = 1'b1;
        end
      endcase
    end
    next_s.cfg.temp_sensor_en = active && !next_s.regs.pdn[dcr_pkg::PDN_TS];
    next_s.cfg.regulator_en = next_s.pin_q && !next_s.regs.pdn[dcr_pkg::PDN_VREG];
    // Soft reset clears power-up but must not drop the analog outputs
    next_s.cfg.analog_powered = next_s.pin_q && next_s.stable;
    next_s.cfg.mclk_out_buffer = next_s.pin_q;
    next_s.cfg.channels_unmuted = active && (sa || (next_s.mute_toggled &&
                                  !next_s.regs.dac0[dcr_pkg::DAC0_MUTE]));

    // Ready flags registered so every port comes from a flop
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready = !next_s.w_got && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;
  end

  // State register
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.regs <= REGS_DEFAULT;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign cfg = s.cfg;

endmodule
`default_nettype wire

// ### shared/dcr_pkg.sv
// Constants and carrier types for the clock, reset and mode configuration block
`default_nettype none
package dcr_pkg;
  // Register byte addresses
  localparam logic [31:0] ADDR_CLK0 = 32'h0000_0000;
  localparam logic [31:0] ADDR_CLK1 = 32'h0000_0004;
  localparam logic [31:0] ADDR_DAC0 = 32'h0000_0008;
  localparam logic [31:0] ADDR_DAC1 = 32'h0000_000C;
  localparam logic [31:0] ADDR_PDN  = 32'h0000_0010;
  localparam logic [31:0] ADDR_STAT = 32'h0000_0014;
  // Field positions
  localparam int CLK0_PUP   = 0;
  localparam int CLK0_RATIO = 1;
  localparam int CLK0_SRST  = 4;
  localparam int CLK0_REF   = 6;
  localparam int CLK1_DIRECT = 0;
  localparam int DAC0_MUTE  = 0;
  localparam int DAC0_RATE  = 1;
  localparam int DAC1_ROLE  = 0;
  localparam int DAC1_BCLK  = 1;
  localparam int PDN_TS     = 0;
  localparam int PDN_PLL    = 1;
  localparam int PDN_VREG   = 2;
  // Reset values
  localparam logic [7:0] CLK0_RST = 8'h00;
  localparam logic [7:0] CLK1_RST = 8'h00;
  localparam logic [7:0] DAC0_RST = 8'h01;
  localparam logic [7:0] DAC1_RST = 8'h00;
  localparam logic [7:0] PDN_RST  = 8'h00;
  // Codes and ratios
  localparam logic [1:0] REF_FRAME = 2'h1;
  localparam logic [1:0] RATE_48   = 2'h0;
  localparam logic [1:0] RATE_96   = 2'h1;
  localparam logic [9:0] RATIO_256 = 10'h100;
  localparam logic [9:0] RATIO_384 = 10'h180;
  localparam logic [9:0] RATIO_512 = 10'h200;
  localparam logic [9:0] RATIO_768 = 10'h300;
  localparam logic [4:0] SLOTS_4   = 5'h04;
  localparam logic [4:0] SLOTS_8   = 5'h08;
  localparam logic [4:0] SLOTS_16  = 5'h10;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Stabilisation wait after the reset pin rises
  localparam int unsigned STAB_TIME_MS = 300;
  localparam int unsigned CLK_KHZ      = 250000;
  localparam int unsigned STAB_CYCLES  = STAB_TIME_MS * CLK_KHZ;

  typedef struct packed {
    logic [7:0] clk0;
    logic [7:0] clk1;
    logic [7:0] dac0;
    logic [7:0] dac1;
    logic [7:0] pdn;
  } dcr_regs_t;

  typedef struct packed {
    logic standalone;
    logic role;
    logic ratio;
    logic fmt;
    logic tdm_a;
    logic tdm_b;
  } dcr_strap_t;

  typedef struct packed {
    logic       core_enable;
    logic       pll_enable;
    logic       pll_ref_frame;
    logic       direct_clock;
    logic       bitclk_gen;
    logic       port_master;
    logic [1:0] rate_range;
    logic [9:0] mclk_ratio;
    logic       tdm_format;
    logic [4:0] tdm_slots;
    logic       frame_50pct;
    logic       temp_sensor_en;
    logic       regulator_en;
    logic       analog_powered;
    logic       mclk_out_buffer;
    logic       channels_unmuted;
    logic       ready;
  } dcr_cfg_t;

  typedef struct packed {
    dcr_regs_t   regs;
    dcr_strap_t  straps;
    dcr_cfg_t    cfg;
    logic        pin_q;
    logic [26:0] stab_cnt;
    logic        stable;
    logic        mute_toggled;
    logic        aw_got;
    logic        w_got;
    logic [31:0] awaddr;
    logic [7:0]  wdata;
    logic        wlane;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } dcr_state_t;
endpackage
`default_nettype wire

// ### test/dcr_assertions.sv
// Port checker for the configuration block
`timescale 1ns/1ps
`default_nettype none
module dcr_assertions #(
  parameter int unsigned STAB_CYCLES = dcr_pkg::STAB_CYCLES
) (
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic              powerup_reset_n,
  input wire logic              standalone_strap,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [31:0]       s_axi_rdata,
  input wire dcr_pkg::dcr_cfg_t cfg
);
  logic [31:0] hi_cnt;
  // Edges seen with the pin high; saturates so it never wraps
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      hi_cnt <= 32'h0;
    else if (!powerup_reset_n)
      hi_cnt <= 32'h0;
    else if (hi_cnt != 32'hFFFF_FFFF)
      hi_cnt <= hi_cnt + 32'h1;
  end
  // Undo the rate scaling to get the ratio at the lowest range
  function automatic logic [11:0] base_ratio(input dcr_pkg::dcr_cfg_t c);
    base_ratio = c.rate_range == 2'h0 ? {2'h0, c.mclk_ratio}
               : c.rate_range == 2'h1 ? {1'b0, c.mclk_ratio, 1'b0} : {c.mclk_ratio, 2'h0};
  endfunction
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence pin_held_low;
    !powerup_reset_n [*3];
  endsequence
  // Strap must be high at the pin release itself, since only that capture counts
  sequence sa_held;
    !powerup_reset_n ##1 (powerup_reset_n && standalone_strap) ##1 powerup_reset_n [*5];
  endsequence
  pin_low_a: assert property (pin_held_low |-> !cfg.core_enable && !cfg.pll_enable && cfg.mclk_ratio == 10'h000)
    else $error("config active while reset pin low");
  stab_wait_a: assert property (cfg.analog_powered && powerup_reset_n |-> hi_cnt >= STAB_CYCLES)
    else $error("powered before stabilisation time");
  stab_done_a: assert property (hi_cnt == STAB_CYCLES + 5 |-> cfg.analog_powered)
    else $error("not powered after stabilisation time");
  ratio_legal_a: assert property (cfg.pll_enable |->
    base_ratio(cfg) inside {12'h100, 12'h180, 12'h200, 12'h300}) else $error("illegal clock ratio");
  direct_ratio_a: assert property (cfg.direct_clock |-> base_ratio(cfg) == 12'h200)
    else $error("direct clock ratio wrong");
  sa_clock_a: assert property (sa_held |-> cfg.mclk_out_buffer && cfg.pll_enable)
    else $error("standalone clock path off");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answering");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answering");
endmodule
bind dcr_top dcr_assertions #(.STAB_CYCLES(STAB_CYCLES)) u_dcr_assertions (
  .mclk(mclk), .rst(rst), .powerup_reset_n(powerup_reset_n), .standalone_strap(standalone_strap),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .cfg(cfg));
`default_nettype wire

// ### test/dcr_host_model.sv
// Host model: register bus master, reset pin and strap levels
`timescale 1ns/1ps
`default_nettype none
module dcr_host_model (
  input  wire logic        mclk,
  output logic             powerup_reset_n,
  output logic [5:0]       straps,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_awaddr,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  input  wire logic [1:0]  s_axi_bresp,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  output logic [31:0]      s_axi_araddr,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp
);
  int slow = 0;
  // Pin pulled low and bus idle from power-on
  initial
  begin
    {powerup_reset_n, straps, s_axi_awvalid, s_axi_awaddr, s_axi_wvalid, s_axi_wdata} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_araddr, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
  end
  // Address and data offered together; a slow host delays bready
  task automatic wr(input logic [31:0] a, input logic [7:0] v, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (slow == 0);
    forever
    begin
      @(posedge mclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (n >= slow) s_axi_bready <= 1'b1;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (slow == 0);
    forever
    begin
      @(posedge mclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (n >= slow) s_axi_rready <= 1'b1;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Straps settle while the pin is low, then the pin is released
  task automatic power_cycle(input logic [5:0] s, input int hold);
    @(posedge mclk);
    powerup_reset_n <= 1'b0;
    repeat (3) @(posedge mclk);
    straps <= s;
    @(posedge mclk);
    powerup_reset_n <= 1'b1;
    repeat (hold) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// ### test/dcr_top_tb.sv
// Self-checking bench for the clock, reset and mode block
`timescale 1ns/1ps
`default_nettype none
module dcr_top_tb;
  localparam int unsigned STAB = 20;
  logic              mclk = 1'b0;
  logic              rst = 1'b1;
  logic              powerup_reset_n;
  logic [5:0]        st;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0]       s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, r;
  dcr_pkg::dcr_cfg_t cfg;
  int                err_count = 0;
  int                n_compared = 0;
  int                cycles = 0;

  always #2 mclk = ~mclk;

  dcr_top #(.STAB_CYCLES(STAB)) u_dcr_top (.mclk, .rst, .powerup_reset_n, .standalone_strap(st[5]),
    .role_strap(st[4]), .ratio_strap(st[3]), .format_strap(st[2]), .tdm_variant_strap_a(st[1]),
    .tdm_variant_strap_b(st[0]), .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .cfg);
  dcr_host_model u_dcr_host_model (.mclk, .powerup_reset_n, .straps(st), .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp);

  // Hang guard; the run needs a few hundred cycles
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      $display("ERROR %0t timeout", $time);
      finish_test;
    end
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t response %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] v);
    u_dcr_host_model.wr(a, v, r);
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    u_dcr_host_model.rd(a, d, r);
    chk_val(d, exp);
  endtask

  task automatic t_reset;
    chk_val({cfg.core_enable, cfg.pll_enable}, 0);
    rd_chk(dcr_pkg::ADDR_DAC0, 32'h1);
    u_dcr_host_model.power_cycle(6'h00, STAB - 5);
    chk_val({cfg.analog_powered, cfg.ready}, 2'h0);
    repeat (11) @(posedge mclk);
    chk_val({cfg.analog_powered, cfg.ready}, 2'h3);
    wr(32'h0000_0020, 8'hFF);
    chk_resp(r, dcr_pkg::RESP_SLVERR);
    rd_chk(32'h0000_0018, 32'h0);
    chk_resp(r, dcr_pkg::RESP_SLVERR);
    $display("t_reset done");
  endtask
  // Power up first, unmute last, with a slow host
  task automatic t_mute;
    wr(dcr_pkg::ADDR_CLK0, 8'h01);
    chk_val(cfg.pll_enable, 1);
    chk_val(cfg.channels_unmuted, 0);
    u_dcr_host_model.slow = 3;
    wr(dcr_pkg::ADDR_DAC0, 8'h00);
    chk_resp(r, dcr_pkg::RESP_OKAY);
    rd_chk(dcr_pkg::ADDR_STAT, 32'h3B);
    u_dcr_host_model.slow = 0;
    chk_val(cfg.channels_unmuted, 1);
    $display("t_mute done");
  endtask
  task automatic t_ratio;
    logic [9:0] base [4] = '{dcr_pkg::RATIO_256, dcr_pkg::RATIO_384, dcr_pkg::RATIO_512, dcr_pkg::RATIO_768};
    for (int rr = 0; rr < 4; rr++)
    begin
      wr(dcr_pkg::ADDR_DAC0, 8'(rr * 2));
      for (int m = 0; m < 4; m++)
      begin
        wr(dcr_pkg::ADDR_CLK0, 8'(m * 2 + 1));
        chk_val(cfg.rate_range, rr);
        chk_val(cfg.mclk_ratio, base[m] >> (rr > 1 ? 2 : rr));
      end
    end
    $display("t_ratio done");
  endtask
  task automatic t_clk;
    wr(dcr_pkg::ADDR_CLK0, 8'h41);
    chk_val({cfg.pll_ref_frame, cfg.pll_enable}, 2'h3);
    wr(dcr_pkg::ADDR_DAC1, 8'h02);
    chk_val({cfg.bitclk_gen, cfg.port_master}, 2'h2);
    wr(dcr_pkg::ADDR_CLK0, 8'h01);
    chk_val({cfg.pll_ref_frame, cfg.bitclk_gen}, 2'h1);
    $display("t_clk done");
  endtask
  task automatic t_pdn;
    for (int i = 0; i < 3; i++)
    begin
      wr(dcr_pkg::ADDR_PDN, 8'(1 << i));
      chk_val({cfg.temp_sensor_en, cfg.pll_enable, cfg.regulator_en}, 3'h7 ^ (3'h4 >> i));
    end
    wr(dcr_pkg::ADDR_PDN, 8'h02);
    wr(dcr_pkg::ADDR_CLK1, 8'h01);
    wr(dcr_pkg::ADDR_DAC0, 8'h00);
    chk_val({cfg.direct_clock, cfg.mclk_ratio}, {1'b1, dcr_pkg::RATIO_512});
    wr(dcr_pkg::ADDR_DAC0, 8'h02);
    chk_val(cfg.mclk_ratio, dcr_pkg::RATIO_256);
    $display("t_pdn done");
  endtask
  // Idle keeps registers; soft reset restores them
  task automatic t_idle_srst;
    wr(dcr_pkg::ADDR_CLK0, 8'h00);
    chk_val(cfg.core_enable, 0);
    rd_chk(dcr_pkg::ADDR_DAC0, 32'h02);
    rd_chk(dcr_pkg::ADDR_PDN, 32'h02);
    wr(dcr_pkg::ADDR_CLK0, 8'h11);
    rd_chk(dcr_pkg::ADDR_CLK0, 32'h0);
    rd_chk(dcr_pkg::ADDR_DAC0, 32'h1);
    rd_chk(dcr_pkg::ADDR_CLK1, 32'h0);
    // Low byte lane off: answered OKAY, nothing stored
    @(posedge mclk);
    u_dcr_host_model.s_axi_wstrb <= 4'hE;
    wr(dcr_pkg::ADDR_DAC1, 8'h03);
    chk_resp(r, dcr_pkg::RESP_OKAY);
    rd_chk(dcr_pkg::ADDR_DAC1, {24'h00_0000, dcr_pkg::DAC1_RST});
    u_dcr_host_model.s_axi_wstrb <= 4'hF;
    chk_val(cfg.analog_powered, 1);
    $display("t_idle_srst done");
  endtask
  task automatic t_standalone;
    logic [4:0] slots [5] = '{dcr_pkg::SLOTS_4, dcr_pkg::SLOTS_8, dcr_pkg::SLOTS_16, dcr_pkg::SLOTS_8, 5'h00};
    for (int i = 0; i < 5; i++)
    begin
      u_dcr_host_model.power_cycle({1'b1, i[0], i[1], i < 4, i[1], i[0]}, STAB + 8);
      chk_val(cfg.port_master, !i[0]);
      chk_val(cfg.mclk_ratio, i[1] ? dcr_pkg::RATIO_384 : dcr_pkg::RATIO_256);
      chk_val({cfg.pll_enable, cfg.tdm_format}, {1'b1, i < 4});
      chk_val({cfg.tdm_slots, cfg.frame_50pct}, {slots[i], i == 3});
      chk_val({cfg.mclk_out_buffer, cfg.rate_range}, {1'b1, dcr_pkg::RATE_48});
    end
    @(posedge mclk);
    u_dcr_host_model.straps <= 6'h3F;
    repeat (4) @(posedge mclk);
    chk_val({cfg.port_master, cfg.mclk_ratio, cfg.tdm_format}, {1'b1, dcr_pkg::RATIO_256, 1'b0});
    wr(dcr_pkg::ADDR_DAC1, 8'h03);
    rd_chk(dcr_pkg::ADDR_DAC1, 32'h0);
    $display("t_standalone done");
  endtask

  task automatic finish_test;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Main sequence after the reset hold
  initial
  begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    t_reset;
    t_mute;
    t_ratio;
    t_clk;
    t_pdn;
    t_idle_srst;
    t_standalone;
    finish_test;
  end
endmodule
`default_nettype wire
